// >>> common/smpc_defs.svh
// Register offsets, field positions, reset values and limits of the modem control block.
// ============================================================
// How it works
// - Modem swap through operating-state register happens only while in Sleep.
// - Selecting spread modem remaps configuration addresses to spread settings.
// - Spread modem owns a dual-port data FIFO reached over the register port.
// - Spread ratio field accepts 6..12; chips per symbol is two to that.
// - Both link ends use the same spread ratio, set in advance.
// - FEC ratio 1..4 selects 4/5, 4/6, 4/7, 4/8.
// - Selected FEC ratio can be placed in the transmitted header.
// - Explicit header is sent at rate 4/8, carrying rate and CRC flag.
// - Symbol rate equals bandwidth divided by two to the spread ratio.
`ifndef SMPC_DEFS_SVH
`define SMPC_DEFS_SVH
// ============================================================
// Byte addresses.
`define SMPC_FIFO_ADDR 8'h00
`define SMPC_OPMODE_ADDR 8'h04
`define SMPC_CFG1_ADDR 8'h1c
`define SMPC_CFG2_ADDR 8'h20
`define SMPC_TUNE_ADDR 8'h24
`define SMPC_LEVEL_ADDR 8'h28
`define SMPC_HDR_ADDR 8'h2c
`define SMPC_FSTAT_ADDR 8'h30
`define SMPC_FSK_CFG_ADDR 8'h1c
// ============================================================
// Fields.
`define SMPC_MODE_LSB 0
`define SMPC_MODE_MSB 2
`define SMPC_SEL_BIT 7
`define SMPC_SR_LSB 4
`define SMPC_SR_MSB 7
`define SMPC_FEC_LSB 1
`define SMPC_FEC_MSB 3
`define SMPC_IMPL_BIT 0
`define SMPC_CRC_BIT 4
// ============================================================
// Reset values and limits.
`define SMPC_MODE_SLEEP 3'h0
`define SMPC_MODE_STBY 3'h1
`define SMPC_OPMODE_RST 8'h01
`define SMPC_CFG1_RST 8'h72
`define SMPC_CFG2_RST 8'h70
`define SMPC_TUNE_RST 8'hc3
`define SMPC_LEVEL_RST 8'h0a
`define SMPC_FSK_CFG_RST 8'h00
`define SMPC_SR_MIN 4'h6
`define SMPC_SR_MAX 4'hc
`define SMPC_FEC_MIN 3'h1
`define SMPC_FEC_MAX 3'h4
`define SMPC_FEC_HDR 3'h4
`endif

// >>> common/smpc_pkg.sv
// Types shared by the modem control block.
package smpc_pkg;
	typedef enum logic [1:0]
	{
		SMPC_IDLE = 2'b00,
		SMPC_DATA = 2'b01
	} smpc_bus_type;
endpackage

// >>> common/smpc_fifo_if.sv
// Carrier between the control block and its data buffer.
interface smpc_fifo_if #(parameter int W = 8, parameter int AW = 8);
	logic wr_en;
	logic [W-1:0] wr_data;
	logic [AW-1:0] wr_addr;
	logic [AW-1:0] rd_addr;
	logic [W-1:0] rd_data;
	modport ctrl (output wr_en, output wr_data, output wr_addr,
		output rd_addr, input rd_data);
	modport mem (input wr_en, input wr_data, input wr_addr,
		input rd_addr, output rd_data);
endinterface

// >>> rtl/smpc_dpram.sv
// Dual-port data buffer of the spread modem.
module smpc_dpram
	import smpc_pkg::*;
#(
	parameter int W = 8,
	parameter int AW = 8
)
(
	// Clock.
	input wire logic hclk,
	// Buffer ports.
	smpc_fifo_if.mem port
);
	logic [W-1:0] mem_q [0:(1<<AW)-1];

	// Independent write and read ports. The read is combinational so that
	// the control block can register the byte straight into its read data.
	always_ff @(posedge hclk)
	begin
		if (port.wr_en)
		begin
			mem_q[port.wr_addr] <= port.wr_data;
		end
	end

	assign port.rd_data = mem_q[port.rd_addr];
endmodule // smpc_dpram

// >>> rtl/smpc_ctrl.sv
// Spread modem parameter control with AHB-Lite register access.
//
// The placing of the registers and the AHB-Lite slave port were decided locally.
`include "smpc_defs.svh"
module smpc_ctrl
	import smpc_pkg::*;
#(
	parameter int FIFO_AW = 8
)
(
	// Clock and reset.
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave.
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Modem settings toward the datapath.
	output logic spread_sel,
	output logic [3:0] spread_ratio,
	output logic [12:0] chips_per_symbol,
	output logic [2:0] fec_ratio,
	output logic [2:0] hdr_fec_ratio,
	output logic [2:0] tx_fec_ratio,
	output logic implicit_hdr,
	output logic [7:0] detect_tuning,
	output logic [7:0] detect_level
);
	logic [7:0] opmode_q;
	logic sel_q;
	logic [7:0] cfg1_q;
	logic [7:0] cfg2_q;
	logic [7:0] tune_q;
	logic [7:0] level_q;
	logic [7:0] fsk_cfg_q;
	logic [7:0] hdr_q;
	logic [FIFO_AW-1:0] wp_q;
	logic [FIFO_AW-1:0] rp_q;
	logic [FIFO_AW:0] cnt_q;
	smpc_bus_type ph_q;
	logic wr_q;
	logic [7:0] adr_q;
	logic [31:0] hrdata_q;
	logic [2:0] cfg_fec_q;
	logic [3:0] cfg_sr_q;
	logic take;
	logic do_wr;
	logic do_rd;
	logic fifo_wr;
	logic fifo_rd;
	logic [31:0] rd_mux;

	smpc_fifo_if #(.W(8), .AW(FIFO_AW)) fifo ();

	smpc_dpram #(.W(8), .AW(FIFO_AW)) u_buf
	(
		.hclk(hclk),
		.port(fifo.mem)
	);

	// Whether a byte address lands on the spread modem's own settings.
	function automatic logic spread_reg(input logic [7:0] a, input logic s);
		spread_reg = s && (a == `SMPC_CFG1_ADDR || a == `SMPC_CFG2_ADDR
			|| a == `SMPC_TUNE_ADDR || a == `SMPC_LEVEL_ADDR
			|| a == `SMPC_HDR_ADDR || a == `SMPC_FSTAT_ADDR);
	endfunction

	// Clamp the spread ratio into its legal range.
	function automatic logic [3:0] clamp_sr(input logic [3:0] v);
		if (v < `SMPC_SR_MIN)
			clamp_sr = `SMPC_SR_MIN;
		else if (v > `SMPC_SR_MAX)
			clamp_sr = `SMPC_SR_MAX;
		else
			clamp_sr = v;
	endfunction

	// Clamp the FEC ratio into its legal range.
	function automatic logic [2:0] clamp_fec(input logic [2:0] v);
		if (v < `SMPC_FEC_MIN)
			clamp_fec = `SMPC_FEC_MIN;
		else if (v > `SMPC_FEC_MAX)
			clamp_fec = `SMPC_FEC_MAX;
		else
			clamp_fec = v;
	endfunction

	// ============================================================
	// Bus phase tracking.
	assign take = hsel && hready && htrans[1];
	assign do_wr = (ph_q == SMPC_DATA) && wr_q;
	assign do_rd = take && !hwrite;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ph_q <= SMPC_IDLE;
			wr_q <= 1'b0;
			adr_q <= 8'h00;
		end
		else if (hready)
		begin
			ph_q <= take ? SMPC_DATA : SMPC_IDLE;
			wr_q <= take && hwrite;
			adr_q <= haddr[7:0];
		end
	end

	// ============================================================
	// Operating state and modem select.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			opmode_q <= `SMPC_OPMODE_RST;
			sel_q <= 1'b0;
		end
		else if (do_wr && adr_q == `SMPC_OPMODE_ADDR)
		begin
			opmode_q <= hwdata[7:0];
			// The swap is allowed only from Sleep, so the map never tears.
			if (opmode_q[`SMPC_MODE_MSB:`SMPC_MODE_LSB] == `SMPC_MODE_SLEEP)
				sel_q <= hwdata[`SMPC_SEL_BIT];
			else
				sel_q <= sel_q;
		end
	end

	// ============================================================
	// Spread modem settings, reachable only through the remapped view, and the FSK setting, reachable only outside it.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			cfg1_q <= `SMPC_CFG1_RST;
			cfg2_q <= `SMPC_CFG2_RST;
			tune_q <= `SMPC_TUNE_RST;
			level_q <= `SMPC_LEVEL_RST;
			fsk_cfg_q <= `SMPC_FSK_CFG_RST;
		end
		else if (do_wr)
		begin
			if (spread_reg(adr_q, sel_q))
			begin
				case (adr_q)
					`SMPC_CFG1_ADDR: cfg1_q <= hwdata[7:0];
					`SMPC_CFG2_ADDR: cfg2_q <= hwdata[7:0];
					`SMPC_TUNE_ADDR: tune_q <= hwdata[7:0];
					`SMPC_LEVEL_ADDR: level_q <= hwdata[7:0];
					default: ;
				endcase
			end
			else if (!sel_q && adr_q == `SMPC_FSK_CFG_ADDR)
			begin
				fsk_cfg_q <= hwdata[7:0];
			end
		end
	end

	// ============================================================
	// Data buffer pointers; writes and reads of the buffer address.
	assign fifo_wr = do_wr && sel_q && adr_q == `SMPC_FIFO_ADDR
		&& cnt_q != (FIFO_AW+1)'(1 << FIFO_AW);
	assign fifo_rd = do_rd && sel_q && haddr[7:0] == `SMPC_FIFO_ADDR
		&& cnt_q != '0;
	assign fifo.wr_en = fifo_wr;
	assign fifo.wr_data = hwdata[7:0];
	assign fifo.wr_addr = wp_q;
	assign fifo.rd_addr = rp_q;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
		end
		else
		begin
			if (fifo_wr)
				wp_q <= wp_q + 1'b1;
			if (fifo_rd)
				rp_q <= rp_q + 1'b1;
			cnt_q <= cnt_q + (FIFO_AW+1)'(fifo_wr) - (FIFO_AW+1)'(fifo_rd);
		end
	end

	// ============================================================
	// Header: explicit header sent at 4/8, carrying rate and CRC flag.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hdr_q <= 8'h00;
			hdr_fec_ratio <= `SMPC_FEC_HDR;
			tx_fec_ratio <= `SMPC_FEC_MIN;
		end
		else
		begin
			hdr_q <= {4'h0, cfg_fec_q, cfg1_q[`SMPC_CRC_BIT]};
			hdr_fec_ratio <= `SMPC_FEC_HDR;
			tx_fec_ratio <= cfg_fec_q;
		end
	end

	// ============================================================
	// Decoded settings toward the modem datapath.
	assign cfg_sr_q = clamp_sr(cfg2_q[`SMPC_SR_MSB:`SMPC_SR_LSB]);
	assign cfg_fec_q = clamp_fec(cfg1_q[`SMPC_FEC_MSB:`SMPC_FEC_LSB]);

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			spread_sel <= 1'b0;
			spread_ratio <= `SMPC_SR_MIN;
			chips_per_symbol <= 13'h0040;
			fec_ratio <= `SMPC_FEC_MIN;
			implicit_hdr <= 1'b0;
			detect_tuning <= `SMPC_TUNE_RST;
			detect_level <= `SMPC_LEVEL_RST;
		end
		else
		begin
			spread_sel <= sel_q;
			// Same ratio must be set on both ends; nothing checks it here.
			spread_ratio <= cfg_sr_q;
			// Symbol period in chips; symbol rate is bandwidth over this.
			chips_per_symbol <= 13'h0001 << cfg_sr_q;
			fec_ratio <= cfg_fec_q;
			implicit_hdr <= cfg1_q[`SMPC_IMPL_BIT];
			detect_tuning <= tune_q;
			detect_level <= level_q;
		end
	end

	// ============================================================
	// Read data: registered one cycle after the address phase.
	always_comb
	begin
		rd_mux = 32'h0000_0000;
		if (haddr[7:0] == `SMPC_OPMODE_ADDR)
			rd_mux = {24'h00_0000, sel_q, opmode_q[6:0]};
		else if (spread_reg(haddr[7:0], sel_q))
		begin
			case (haddr[7:0])
				`SMPC_CFG1_ADDR: rd_mux = {24'h00_0000, cfg1_q};
				`SMPC_CFG2_ADDR: rd_mux = {24'h00_0000, cfg2_q};
				`SMPC_TUNE_ADDR: rd_mux = {24'h00_0000, tune_q};
				`SMPC_LEVEL_ADDR: rd_mux = {24'h00_0000, level_q};
				`SMPC_HDR_ADDR: rd_mux = {24'h00_0000, hdr_q};
				`SMPC_FSTAT_ADDR: rd_mux = 32'(cnt_q);
				default: rd_mux = 32'h0000_0000;
			endcase
		end
		else if (!sel_q && haddr[7:0] == `SMPC_FSK_CFG_ADDR)
			rd_mux = {24'h00_0000, fsk_cfg_q};
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hrdata_q <= 32'h0000_0000;
		end
		else if (do_rd)
		begin
			// Buffer bytes are taken at the address edge, which also pops.
			if (fifo_rd)
				hrdata_q <= {24'h00_0000, fifo.rd_data};
			else
				hrdata_q <= rd_mux;
		end
	end

	// Read data come straight from a register.
	assign hrdata = hrdata_q;

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
endmodule // smpc_ctrl

// >>> test/smpc_ctrl_assertions.sv
// Checker of the modem control block port rules.
module smpc_ctrl_assertions
(
	// Clock, reset and bus.
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	// Settings.
	input wire logic spread_sel,
	input wire logic [3:0] spread_ratio,
	input wire logic [12:0] chips_per_symbol,
	input wire logic [2:0] fec_ratio,
	input wire logic [2:0] hdr_fec_ratio,
	input wire logic [2:0] tx_fec_ratio
);
	timeunit 1ns;
	timeprecision 1ps;
	logic op_q, un_q;
	logic [2:0] mode_q;
	wire logic take = hsel & hready & htrans[1];
	wire logic [7:0] adr = haddr[7:0];
	// ====
	// Shadow of the address phase, so data phase checks know the target.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			op_q <= 1'h0;
			un_q <= 1'h0;
		end
		else
		begin
			op_q <= take & hwrite & (adr == 8'h04);
			un_q <= take & !hwrite & ((adr > 8'h30) |
				(!spread_sel & (adr >= 8'h20)));
		end
	end
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			mode_q <= 3'h1;
		else if (op_q)
			mode_q <= hwdata[2:0];
	end
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	property p_ready;
		hreadyout && !hresp;
	endproperty
	a_ready: assert property (p_ready)
		else $error("bus answer is not zero-wait OKAY");
	property p_ratio;
		spread_ratio inside {[4'h6:4'hc]};
	endproperty
	a_ratio: assert property (p_ratio)
		else $error("spread ratio out of range");
	property p_chips;
		$stable(spread_ratio)[*2] |->
			chips_per_symbol == (13'h0001 << spread_ratio);
	endproperty
	a_chips: assert property (p_chips)
		else $error("chips per symbol wrong");
	property p_fec;
		fec_ratio inside {[3'h1:3'h4]};
	endproperty
	a_fec: assert property (p_fec)
		else $error("fec ratio out of range");
	property p_hdr;
		hdr_fec_ratio == 3'h4;
	endproperty
	a_hdr: assert property (p_hdr)
		else $error("header fec ratio not strongest");
	property p_tx;
		$stable(fec_ratio)[*2] |-> tx_fec_ratio == fec_ratio;
	endproperty
	a_tx: assert property (p_tx)
		else $error("transmitted fec ratio differs");
	property p_hold;
		op_q && mode_q != 3'h0 |-> ##2 $stable(spread_sel);
	endproperty
	a_hold: assert property (p_hold)
		else $error("modem changed outside sleep");
	property p_swap;
		op_q && mode_q == 3'h0 && hwdata[7] |-> ##[1:2] spread_sel;
	endproperty
	a_swap: assert property (p_swap)
		else $error("modem not swapped in sleep");
	property p_unmap;
		un_q |-> hrdata == 32'h0000_0000;
	endproperty
	a_unmap: assert property (p_unmap)
		else $error("unmapped read not zero");
endmodule // smpc_ctrl_assertions
bind smpc_ctrl smpc_ctrl_assertions u_smpc_ctrl_assertions (.hclk,
	.hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
	.hrdata, .hreadyout, .hresp, .spread_sel, .spread_ratio,
	.chips_per_symbol, .fec_ratio, .hdr_fec_ratio, .tx_fec_ratio);

// >>> test/smpc_host_model.sv
// Host model that drives the register bus of the modem control block.
module smpc_host_model
(
	// Clock.
	input wire logic hclk,
	// Bus toward the block.
	output logic hsel,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		hsel = 1'h1;
		haddr = 32'h0000_0000;
		htrans = 2'h0;
		hwrite = 1'h0;
		hsize = 3'h2;
		hwdata = 32'h0000_0000;
	end
	// ====
	// One single word transfer; call right after a rising edge.
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		haddr <= {24'h00_0000, a};
		hwrite <= w;
		htrans <= 2'h2;
		@(posedge hclk);
		while (hready !== 1'h1)
			@(posedge hclk);
		htrans <= 2'h0;
		hwdata <= w ? d : ~hwdata;
		@(posedge hclk);
		while (hready !== 1'h1)
			@(posedge hclk);
		q = hrdata;
		hwdata <= ~d;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(1'h1, a, d, q);
	endtask
	// Modem swap is only asked for from Sleep.
	task automatic select_spread();
		wr(8'h04, 32'h0000_0000);
		wr(8'h04, 32'h0000_0080);
	endtask
	task automatic set_spread(input logic [3:0] sf, input logic [2:0] f);
		logic six;
		six = (sf == 4'h6);
		wr(8'h20, {24'h00_0000, sf, 4'h0});
		wr(8'h1c, {28'h000_0000, f, six});
		wr(8'h24, six ? 32'h0000_00c5 : 32'h0000_00c3);
		wr(8'h28, six ? 32'h0000_000c : 32'h0000_000a);
	endtask
endmodule // smpc_host_model

// >>> test/spread_modem_parameter_control_tb.sv
// Self-checking bench for the modem control block.
module spread_modem_parameter_control_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, spread_sel;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize, fec_ratio, hdr_fec_ratio, tx_fec_ratio;
	logic [3:0] spread_ratio;
	logic [12:0] chips_per_symbol;
	logic [7:0] detect_tuning, detect_level, b;
	logic implicit_hdr;
	int errors, num_checks, seed, k;
	typedef struct {string nm; logic [31:0] v;} smpc_note_type;
	smpc_note_type exp_q[$];
	logic [31:0] seen_q[$];
	logic [7:0] buf_q[$];
	smpc_host_model u_smpc_host_model (.hclk, .hsel, .haddr, .htrans,
		.hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata);
	smpc_ctrl #(.FIFO_AW(8)) u_smpc_ctrl (.hclk, .hresetn, .hsel, .haddr,
		.htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata,
		.hreadyout, .hresp, .spread_sel, .spread_ratio, .chips_per_symbol,
		.fec_ratio, .hdr_fec_ratio, .tx_fec_ratio, .implicit_hdr,
		.detect_tuning, .detect_level);
	initial
	begin
		hclk = 1'h0;
		forever
			#2.5 hclk = ~hclk;
	end
	// ====
	// Notes, comparison and closing.
	task automatic check(string nm, logic [31:0] s, logic [31:0] e);
		num_checks++;
		if (s !== e)
		begin
			errors++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic outp(string nm, logic [31:0] e, logic [31:0] s);
		exp_q.push_back('{nm, e});
		seen_q.push_back(s);
	endtask
	task automatic rd(string nm, logic [7:0] a, logic [31:0] e);
		logic [31:0] r;
		exp_q.push_back('{nm, e});
		u_smpc_host_model.xfer(1'h0, a, 32'h0000_0000, r);
		seen_q.push_back(r);
	endtask
	task automatic wr(logic [7:0] a, logic [31:0] d);
		u_smpc_host_model.wr(a, d);
	endtask
	// Decoded outputs trail the register write by one more cycle.
	task automatic settle();
		repeat (2) @(posedge hclk);
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial
	begin : monitor
		smpc_note_type n;
		forever
		begin
			@(posedge hclk);
			while (seen_q.size() > 0)
			begin
				n = exp_q.pop_front();
				check(n.nm, seen_q.pop_front(), n.v);
			end
		end
	end
	initial
	begin
		#200000;
		errors++;
		final_report();
	end
	initial
	begin
		seed = 32'h7e46_4452;
		hresetn = 1'h0;
		repeat (12) @(posedge hclk);
		hresetn <= 1'h1;
		@(posedge hclk);
		rd("opmode", 8'h04, 32'h0000_0001);
		wr(8'h04, 32'h0000_0081);
		rd("opmode", 8'h04, 32'h0000_0001);
		rd("cfg2 hidden", 8'h20, 32'h0000_0000);
		rd("fsk cfg", 8'h1c, 32'h0000_0000);
		u_smpc_host_model.select_spread();
		settle();
		outp("sel", 32'h0000_0001, 32'(spread_sel));
		rd("cfg1", 8'h1c, 32'h0000_0072);
		rd("cfg2", 8'h20, 32'h0000_0070);
		rd("tune", 8'h24, 32'h0000_00c3);
		rd("level", 8'h28, 32'h0000_000a);
		rd("unmapped", 8'h40, 32'h0000_0000);
		$display("test modem select done");
		for (int sf = 5; sf <= 13; sf++)
		begin
			k = sf < 6 ? 6 : (sf > 12 ? 12 : sf);
			u_smpc_host_model.set_spread(4'(sf), 3'h2);
			settle();
			outp("ratio", 32'(k), 32'(spread_ratio));
			outp("chips", 32'h0000_0001 << k, 32'(chips_per_symbol));
			outp("impl", 32'(sf == 6), 32'(implicit_hdr));
			outp("tune", sf == 6 ? 32'h0000_00c5 : 32'h0000_00c3,
				32'(detect_tuning));
			outp("level", sf == 6 ? 32'h0000_000c : 32'h0000_000a,
				32'(detect_level));
		end
		$display("test spread ratio done");
		for (int f = 0; f < 8; f++)
		begin
			wr(8'h1c, 32'(f << 1));
			settle();
			k = f < 1 ? 1 : (f > 4 ? 4 : f);
			outp("fec", 32'(k), 32'(fec_ratio));
			outp("tx fec", 32'(k), 32'(tx_fec_ratio));
			outp("hdr fec", 32'h0000_0004, 32'(hdr_fec_ratio));
			rd("hdr", 8'h2c, 32'(k << 1));
		end
		$display("test fec ratio done");
		rd("count", 8'h30, 32'h0000_0000);
		repeat (4)
		begin
			b = 8'($random(seed));
			buf_q.push_back(b);
			wr(8'h00, {24'h00_0000, b});
		end
		rd("count", 8'h30, 32'h0000_0004);
		while (buf_q.size() > 0)
			rd("buffer", 8'h00, {24'h00_0000, buf_q.pop_front()});
		rd("empty", 8'h00, 32'h0000_0000);
		wr(8'h04, 32'h0000_0081);
		wr(8'h04, 32'h0000_0001);
		rd("opmode", 8'h04, 32'h0000_0081);
		$display("test buffer and hold done");
		// The monitor drains the queue on the next edge.
		repeat (2) @(posedge hclk);
		final_report();
	end
endmodule // spread_modem_parameter_control_tb
